/* design/avdc_regs.sv */
// avdc_regs: serial-port register bank for volume, supply supervision, limiter and clip settings
`default_nettype none
module avdc_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h34 // arbitrary default
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // serial control port, open drain data
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // output stage supervision
  input wire logic [15:0] hi_supply_mv,
  input wire logic over_supply_event,
  input wire logic fade_done,
  output logic hi_supply_low_q,
  output logic fade_req_q,
  output logic speaker_off_q,
  output logic logic_supply_low_fade_off,
  // channel gain, attenuation in half-dB below +24 dB
  output logic [8:0] left_atten_q,
  output logic left_silent_q,
  output logic [8:0] right_atten_q,
  output logic right_silent_q,
  // processing features
  output logic left_mixing_on,
  output logic right_mixing_on,
  output logic left_clip_on,
  output logic right_clip_on,
  output logic left_limiter_on,
  output logic right_limiter_on,
  output logic mono_on,
  output logic [3:0] limiter_attack_rate,
  output logic [3:0] limiter_release_rate,
  output logic [23:0] limiter_threshold,
  output logic [23:0] clip_level
);
  import avdc_pkg::*;

  if (DEV_ADDR == 7'h00) begin : g_bad_addr
    $error("device address zero is the general call");
  end

  // register storage
  logic [7:0] master_gain_code, left_gain_code, right_gain_code;
  logic [7:0] supply_q, feat_q, rates_q;
  logic [7:0] limiter_threshold_top_byte, limiter_threshold_mid_byte, limiter_threshold_low_byte;
  logic [7:0] clip_top_byte, clip_mid_byte, clip_low_byte;

  // serial port state
  avdc_sp_t sp_q, sp_d;
  logic scl_q, sda_q;
  logic [7:0] sr_q, sr_d, ptr_q, ptr_d;
  logic [3:0] cnt_q, cnt_d;
  logic rw_q, rw_d, first_q, first_d, nack_q, nack_d, oe_n_d;

  // bus events from previous samples
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_ev = scl & scl_q & sda_q & ~sda_in;
  wire stop_ev = scl & scl_q & ~sda_q & sda_in;
  wire addr_hit = (sr_q[7:1] == DEV_ADDR);
  wire wr_en = (sp_q == SP_WR) & scl_fall & (cnt_q == 4'h8) & ~first_q;

  // read mux, unmapped offsets read zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    case (a)
      OFS_MASTER: rd_byte = master_gain_code;
      OFS_LEFT: rd_byte = left_gain_code;
      OFS_RIGHT: rd_byte = right_gain_code;
      OFS_SUPPLY: rd_byte = supply_q;
      OFS_FEAT: rd_byte = feat_q;
      OFS_RATES: rd_byte = rates_q;
      OFS_THR_HI: rd_byte = limiter_threshold_top_byte;
      OFS_THR_MID: rd_byte = limiter_threshold_mid_byte;
      OFS_THR_LO: rd_byte = limiter_threshold_low_byte;
      OFS_CLIP_HI: rd_byte = clip_top_byte;
      OFS_CLIP_MID: rd_byte = clip_mid_byte;
      OFS_CLIP_LO: rd_byte = clip_low_byte;
      default: rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  // serial port next state
  always_comb begin
    sp_d = sp_q;
    sr_d = sr_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    rw_d = rw_q;
    first_d = first_q;
    nack_d = nack_q;
    if (start_ev) begin
      sp_d = SP_ADDR;
      cnt_d = 4'h0;
      first_d = 1'b1;
    end else if (stop_ev) begin
      sp_d = SP_IDLE;
    end else begin
      case (sp_q)
        SP_IDLE: begin
          cnt_d = 4'h0;
        end
        SP_ADDR, SP_WR: begin
          if (scl_rise) begin
            sr_d = {sr_q[6:0], sda_in};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            if (sp_q == SP_ADDR) begin
              rw_d = sr_q[0];
              sp_d = addr_hit ? SP_ACK : SP_IDLE;
            end else begin
              sp_d = SP_ACK;
              first_d = 1'b0;
              // first data byte sets the pointer, later bytes auto-increment
              ptr_d = first_q ? sr_q : ptr_q + 8'h01;
            end
          end
        end
        SP_ACK: begin
          if (scl_rise) begin
            cnt_d = 4'h1;
          end else if (scl_fall && cnt_q == 4'h1) begin
            cnt_d = 4'h0;
            sp_d = rw_q ? SP_RD : SP_WR;
            if (rw_q) begin
              sr_d = rd_byte(ptr_q);
            end
          end
        end
        SP_RD: begin
          if (scl_fall) begin
            sr_d = {sr_q[6:0], 1'b0};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              sp_d = SP_RACK;
              cnt_d = 4'h0;
            end
          end
        end
        SP_RACK: begin
          if (scl_rise) begin
            nack_d = sda_in;
            cnt_d = 4'h1;
          end else if (scl_fall && cnt_q == 4'h1) begin
            cnt_d = 4'h0;
            sp_d = nack_q ? SP_IDLE : SP_RD;
            ptr_d = ptr_q + 8'h01;
            sr_d = rd_byte(ptr_q + 8'h01);
          end
        end
        default: begin
          sp_d = SP_IDLE;
        end
      endcase
    end
  end

  // pull data low for acknowledge and for zero read bits
  assign oe_n_d = ~((sp_d == SP_ACK) | ((sp_d == SP_RD) & ~sr_d[7]));

  // serial port flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sp_q <= SP_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sr_q <= 8'h00;
      ptr_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      first_q <= 1'b1;
      nack_q <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sp_q <= sp_d;
      scl_q <= scl;
      sda_q <= sda_in;
      sr_q <= sr_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      rw_q <= rw_d;
      first_q <= first_d;
      nack_q <= nack_d;
      sda_oe_n <= oe_n_d;
    end
  end

  // open-drain data only ever drives low
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      master_gain_code <= RST_GAIN;
      left_gain_code <= RST_GAIN;
      right_gain_code <= RST_GAIN;
      supply_q <= RST_SUPPLY;
      feat_q <= RST_FEAT;
      rates_q <= RST_RATES;
      limiter_threshold_top_byte <= RST_THR_HI;
      limiter_threshold_mid_byte <= RST_THR_LOW;
      limiter_threshold_low_byte <= RST_THR_LOW;
      clip_top_byte <= RST_CLIP_HI;
      clip_mid_byte <= RST_CLIP_LOW;
      clip_low_byte <= RST_CLIP_LOW;
    end else if (wr_en) begin
      case (ptr_q)
        OFS_MASTER: master_gain_code <= sr_q;
        OFS_LEFT: left_gain_code <= sr_q;
        OFS_RIGHT: right_gain_code <= sr_q;
        OFS_SUPPLY: supply_q <= sr_q & MASK_SUPPLY;
        OFS_FEAT: feat_q <= sr_q & MASK_FEAT;
        OFS_RATES: rates_q <= sr_q;
        OFS_THR_HI: limiter_threshold_top_byte <= sr_q;
        OFS_THR_MID: limiter_threshold_mid_byte <= sr_q;
        OFS_THR_LO: limiter_threshold_low_byte <= sr_q;
        OFS_CLIP_HI: clip_top_byte <= sr_q;
        OFS_CLIP_MID: clip_mid_byte <= sr_q;
        OFS_CLIP_LO: clip_low_byte <= sr_q;
        default: ;
      endcase
    end
  end

  assign left_mixing_on = feat_q[LEFT_MIX_BIT];
  assign right_mixing_on = feat_q[RIGHT_MIX_BIT];
  assign left_clip_on = feat_q[LEFT_CLIP_BIT];
  assign right_clip_on = feat_q[RIGHT_CLIP_BIT];
  assign left_limiter_on = feat_q[LEFT_LIM_BIT];
  assign right_limiter_on = feat_q[RIGHT_LIM_BIT];
  assign mono_on = feat_q[MONO_BIT];
  assign limiter_attack_rate = rates_q[ATTACK_LSB+:4];
  assign limiter_release_rate = rates_q[RELEASE_LSB+:4];
  assign limiter_threshold = {limiter_threshold_top_byte, limiter_threshold_mid_byte, limiter_threshold_low_byte};
  // clip level word, full scale at reset
  assign clip_level = {clip_top_byte, clip_mid_byte, clip_low_byte};
  assign logic_supply_low_fade_off = supply_q[LOGIC_FADE_OFF_BIT];

  // total attenuation is the sum of two half-dB codes
  wire [8:0] left_sum = {1'b0, master_gain_code} + {1'b0, left_gain_code};
  wire [8:0] right_sum = {1'b0, master_gain_code} + {1'b0, right_gain_code};
  wire master_mute = master_gain_code > GAIN_CODE_LAST;
  wire left_mute = master_mute | (left_gain_code > GAIN_CODE_LAST) | (left_sum > TOTAL_ATT_LAST);
  wire right_mute = master_mute | (right_gain_code > GAIN_CODE_LAST) | (right_sum > TOTAL_ATT_LAST);

  // registered channel gains
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      left_atten_q <= {1'b0, RST_GAIN} + {1'b0, RST_GAIN};
      right_atten_q <= {1'b0, RST_GAIN} + {1'b0, RST_GAIN};
      left_silent_q <= 1'b0;
      right_silent_q <= 1'b0;
    end else begin
      left_atten_q <= left_sum;
      right_atten_q <= right_sum;
      left_silent_q <= left_mute;
      right_silent_q <= right_mute;
    end
  end

  logic [15:0] uv_mv;
  always_comb begin
    case (supply_q[LEVEL_SEL_LSB+:3])
      3'h1: uv_mv = UV_MV_1;
      3'h2: uv_mv = UV_MV_2;
      3'h3: uv_mv = UV_MV_3;
      3'h4: uv_mv = UV_MV_4;
      3'h5: uv_mv = UV_MV_5;
      default: uv_mv = UV_MV_0;
    endcase
  end

  // detection on when its off bit is clear
  wire uv_now = ~supply_q[HI_LOW_OFF_BIT] & (hi_supply_mv < uv_mv);
  wire ov_now = ~supply_q[OVER_OFF_BIT] & over_supply_event;
  wire ov_fade = ov_now & ~supply_q[OVER_FADE_OFF_BIT];
  wire ov_cut = ov_now & supply_q[OVER_FADE_OFF_BIT];

  // protection sequence
  avdc_prot_t pr_q, pr_d;
  always_comb begin
    pr_d = pr_q;
    case (pr_q)
      PR_RUN: begin
        if (ov_cut) begin
          pr_d = PR_OFF;
        end else if (uv_now | ov_fade) begin
          pr_d = PR_FADE;
        end
      end
      PR_FADE: begin
        if (ov_cut | fade_done) begin
          pr_d = PR_OFF;
        end else if (!(uv_now | ov_fade)) begin
          pr_d = PR_RUN;
        end
      end
      PR_OFF: begin
        if (!(uv_now | ov_now)) begin
          pr_d = PR_RUN;
        end
      end
      default: begin
        pr_d = PR_RUN;
      end
    endcase
  end

  // protection flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pr_q <= PR_RUN;
      fade_req_q <= 1'b0;
      speaker_off_q <= 1'b0;
      hi_supply_low_q <= 1'b0;
    end else begin
      pr_q <= pr_d;
      fade_req_q <= (pr_d == PR_FADE);
      speaker_off_q <= (pr_d == PR_OFF);
      hi_supply_low_q <= uv_now;
    end
  end
endmodule : avdc_regs
`default_nettype wire

/* dv/avdc_host_model.sv */
// avdc_host_model: serial control host that writes and reads the bank
`default_nettype none
module avdc_host_model #(
  parameter logic [6:0] ADDR = 7'h34,
  parameter int PHASE = 4
) (
  // clock
  input wire logic clock,
  // serial port, open drain data
  input wire logic sda_in,
  output var logic scl,
  output var logic sda_h
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle with both lines released
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // one bit: data moves only while clock is low
  task automatic bitx(input logic b, output logic r);
    tick(PHASE);
    sda_h = b;
    tick(PHASE);
    scl = 1'b1;
    tick(PHASE);
    r = sda_in;
    scl = 1'b0;
  endtask : bitx
  task automatic xbyte(input logic [7:0] v, input logic last, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) begin
      bitx(v[i], q[i]);
    end
    bitx(last, r);
  endtask : xbyte
  // start or repeated start
  task automatic start();
    tick(PHASE);
    sda_h = 1'b1;
    tick(PHASE);
    scl = 1'b1;
    tick(PHASE);
    sda_h = 1'b0;
    tick(PHASE);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(PHASE);
    sda_h = 1'b0;
    tick(PHASE);
    scl = 1'b1;
    tick(PHASE);
    sda_h = 1'b1;
    tick(PHASE);
  endtask : stop
  // pointer then one data byte; nak set if any byte went unacknowledged
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] v, output logic nak);
    logic [7:0] q;
    logic r0, r1, r2;
    start();
    xbyte({dev, 1'b0}, 1'b1, q, r0);
    xbyte(a, 1'b1, q, r1);
    xbyte(v, 1'b1, q, r2);
    stop();
    nak = r0 | r1 | r2;
  endtask : wr_reg
  // pointer write, repeated start, one byte read ended by a nack
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    logic [7:0] q;
    logic r;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, q, r);
    xbyte(a, 1'b1, q, r);
    start();
    xbyte({ADDR, 1'b1}, 1'b1, q, r);
    xbyte(8'hFF, 1'b1, v, r);
    stop();
  endtask : rd_reg
  // pointer then three data bytes, top first, stored through the auto-incrementing pointer
  task automatic wr_word(input logic [7:0] a, input logic [23:0] v, output logic nak);
    logic [7:0] q;
    logic r;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, q, r);
    nak = r;
    xbyte(a, 1'b1, q, r);
    nak |= r;
    for (int i = 2; i >= 0; i--) begin
      xbyte(v[i*8+:8], 1'b1, q, r);
      nak |= r;
    end
    stop();
  endtask : wr_word
  // three-byte read, host acks the first two bytes and nacks the last
  task automatic rd_word(input logic [7:0] a, output logic [23:0] v);
    logic [7:0] q;
    logic r;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, q, r);
    xbyte(a, 1'b1, q, r);
    start();
    xbyte({ADDR, 1'b1}, 1'b1, q, r);
    for (int i = 2; i >= 0; i--) begin
      xbyte(8'hFF, i == 0, q, r);
      v[i*8+:8] = q;
    end
    stop();
  endtask : rd_word
endmodule : avdc_host_model
`default_nettype wire

/* dv/avdc_regs_sva.sv */
// avdc_regs_sva: port-level checks on the gain, limiter and clip register bank
`default_nettype none
module avdc_regs_sva (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // serial port
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // supply supervision
  input wire logic [15:0] hi_supply_mv,
  input wire logic over_supply_event,
  input wire logic fade_done,
  input wire logic hi_supply_low_q,
  input wire logic fade_req_q,
  input wire logic speaker_off_q,
  // settings
  input wire logic [8:0] left_atten_q,
  input wire logic left_silent_q,
  input wire logic left_mixing_on,
  input wire logic mono_on,
  input wire logic [23:0] limiter_threshold,
  input wire logic [23:0] clip_level
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_reset_values:
    assert property ($rose(reset_n) |-> left_atten_q == 9'h030 && sda_oe_n
      && limiter_threshold == 24'h200000 && clip_level == 24'h7FFFFF)
    else $error("bank left reset with wrong values");
  a_sda_open_drain:
    assert property (!sda_oe_n |-> !sda_out) else $error("data line driven high");
  a_sda_change_low:
    assert property ($changed(sda_oe_n) |-> !scl) else $error("data line moved while clock high");
  a_config_change_low:
    assert property ($changed({left_mixing_on, mono_on, limiter_threshold, clip_level}) |-> !scl)
    else $error("setting changed outside a write");
  a_silent_range:
    assert property (left_atten_q > 9'h0FE |-> left_silent_q) else $error("total below range not silent");
  a_high_supply_quiet:
    assert property ((hi_supply_mv >= 16'h4C2C) [*2] |-> !hi_supply_low_q)
    else $error("low supply flagged above top level");
  a_low_fades:
    assert property (hi_supply_low_q |-> ##[0:2] (fade_req_q || speaker_off_q))
    else $error("low supply did not fade");
  a_fade_has_cause:
    assert property ($rose(fade_req_q) |-> hi_supply_low_q || $past(hi_supply_low_q) || $past(over_supply_event))
    else $error("fade without a cause");
  a_off_after_done:
    assert property (fade_req_q && fade_done && hi_supply_low_q |=> speaker_off_q)
    else $error("speaker not off after fade");
endmodule : avdc_regs_sva

bind avdc_regs avdc_regs_sva chk_u (.clock, .reset_n, .scl, .sda_out, .sda_oe_n, .hi_supply_mv,
  .over_supply_event, .fade_done, .hi_supply_low_q, .fade_req_q, .speaker_off_q, .left_atten_q,
  .left_silent_q, .left_mixing_on, .mono_on, .limiter_threshold, .clip_level);
`default_nettype wire

/* dv/tb_avdc_regs.sv */
// tb_avdc_regs: self-checking bench for the gain, limiter and clip register bank
`default_nettype none
module tb_avdc_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ADDR = 7'h34;
  logic clock, reset_n, scl, sda_h, sda, sda_out, sda_oe_n, nak;
  logic over_supply_event, fade_done, hi_supply_low_q, fade_req_q, speaker_off_q, logic_supply_low_fade_off;
  logic [15:0] hi_supply_mv;
  logic [8:0] left_atten_q, right_atten_q;
  logic left_silent_q, right_silent_q, left_mixing_on, right_mixing_on, left_clip_on, right_clip_on;
  logic left_limiter_on, right_limiter_on, mono_on;
  logic [3:0] limiter_attack_rate, limiter_release_rate;
  logic [23:0] limiter_threshold, clip_level;
  logic [23:0] burst_w, burst_r;
  logic [7:0] shadow [256];
  logic [7:0] rd;
  logic [7:0] gm [4] = '{8'hE6, 8'h18, 8'h19, 8'hE7};
  logic [7:0] gc [4] = '{8'h00, 8'hE6, 8'hE5, 8'h00};
  logic [15:0] lv [8] = '{16'h0FA0, 16'h2008, 16'h25E4, 16'h3390, 16'h3C8C, 16'h4C2C, 16'h0FA0, 16'h0FA0};
  logic [31:0] seed;
  int fail_count, comparisons;
  // pull-up on the data line, device only pulls low
  assign sda = sda_h & (sda_oe_n | sda_out);

  avdc_regs #(.DEV_ADDR(ADDR)) dut_u (.clock, .reset_n, .scl, .sda_in(sda), .sda_out, .sda_oe_n, .hi_supply_mv,
    .over_supply_event, .fade_done, .hi_supply_low_q, .fade_req_q, .speaker_off_q, .logic_supply_low_fade_off,
    .left_atten_q, .left_silent_q, .right_atten_q, .right_silent_q, .left_mixing_on, .right_mixing_on,
    .left_clip_on, .right_clip_on, .left_limiter_on, .right_limiter_on, .mono_on, .limiter_attack_rate,
    .limiter_release_rate, .limiter_threshold, .clip_level);
  avdc_host_model #(.ADDR(ADDR)) host_u (.clock, .sda_in(sda), .scl, .sda_h);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  // writable bits per offset, zero where nothing is mapped
  function automatic logic [7:0] wmask(input logic [7:0] a);
    if (a == 8'h06) return 8'hF7;
    if (a == 8'h07) return 8'hFE;
    if ((a >= 8'h03 && a <= 8'h08) || (a >= 8'h10 && a <= 8'h15)) return 8'hFF;
    return 8'h00;
  endfunction : wmask
  function automatic logic silent(input logic [7:0] m, input logic [7:0] c);
    return m > 8'hE6 || c > 8'hE6 || ({1'b0, m} + {1'b0, c}) > 9'h0FE;
  endfunction : silent
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host_u.wr_reg(ADDR, a, v, nak);
    shadow[a] = v & wmask(a);
    chk(nak, 1'b0);
  endtask : wr
  task automatic sweep();
    for (int a = 2; a <= 8'h16; a++) begin
      host_u.rd_reg(8'(a), rd);
      chk(rd, shadow[a]);
    end
  endtask : sweep
  task automatic ports();
    chk(left_atten_q, {1'b0, shadow[3]} + {1'b0, shadow[4]});
    chk(right_atten_q, {1'b0, shadow[3]} + {1'b0, shadow[5]});
    chk({left_silent_q, right_silent_q}, {silent(shadow[3], shadow[4]), silent(shadow[3], shadow[5])});
    chk({left_mixing_on, right_mixing_on, left_clip_on, left_limiter_on, mono_on, right_clip_on,
      right_limiter_on, 1'b0}, shadow[7]);
    chk({limiter_attack_rate, limiter_release_rate}, shadow[8]);
    chk(logic_supply_low_fade_off, shadow[6][6]);
    chk(limiter_threshold, {shadow[16], shadow[17], shadow[18]});
    chk(clip_level, {shadow[19], shadow[20], shadow[21]});
  endtask : ports
  task automatic sup(input logic [15:0] mv, input logic ev, input logic fd);
    hi_supply_mv = mv;
    over_supply_event = ev;
    fade_done = fd;
    host_u.tick(3);
  endtask : sup
  task automatic final_report();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  // watchdog against a hung bus, the full run needs about 76k clocks
  initial begin
    repeat (90000) @(posedge clock);
    fail_count++;
    final_report();
  end
  initial begin
    seed = 32'd46;
    reset_n = 1'b0;
    hi_supply_mv = 16'h6000;
    over_supply_event = 1'b0;
    fade_done = 1'b0;
    fail_count = 0;
    comparisons = 0;
    foreach (shadow[a]) shadow[a] = 8'h00;
    shadow[3] = 8'h18;
    shadow[4] = 8'h18;
    shadow[5] = 8'h18;
    shadow[16] = 8'h20;
    shadow[19] = 8'h7F;
    shadow[20] = 8'hFF;
    shadow[21] = 8'hFF;
    repeat (16) @(posedge clock);
    #1;
    reset_n = 1'b1;
    host_u.tick(2);
    ports();
    sweep();
    // all ones, all zeros, then random over the whole map
    for (int p = 0; p < 3; p++) begin
      for (int a = 2; a <= 8'h16; a++) begin
        wr(8'(a), p == 0 ? 8'hFF : p == 1 ? 8'h00 : xs());
      end
      ports();
      sweep();
    end
    // gain codes around the silent boundary
    foreach (gm[i]) begin
      wr(8'h03, gm[i]);
      wr(8'h04, gc[i]);
      wr(8'h05, gc[i] + 8'h01);
      ports();
    end
    // three-byte bursts through the auto-incrementing pointer, top byte lowest
    for (int k = 0; k < 2; k++) begin
      burst_w = {xs(), xs(), xs()};
      host_u.wr_word(8'(16 + 3 * k), burst_w, nak);
      chk(nak, 1'b0);
      {shadow[16 + 3 * k], shadow[17 + 3 * k], shadow[18 + 3 * k]} = burst_w;
      host_u.rd_word(8'(16 + 3 * k), burst_r);
      chk(burst_r, burst_w);
      ports();
    end
    // wrong device address is ignored
    host_u.wr_reg(7'h35, 8'h03, 8'h55, nak);
    chk(nak, 1'b1);
    ports();
    // mono entry with its two extra writes, wiring taken as ready
    wr(8'h07, 8'h08);
    wr(8'h29, 8'h5A);
    wr(8'h2A, 8'hA5);
    host_u.rd_reg(8'h29, rd);
    chk(rd, 8'h00);
    ports();
    // each low-supply level, one below and exactly at it
    for (int s = 0; s < 8; s++) begin
      wr(8'h06, 8'(s));
      sup(lv[s] - 16'h0001, 1'b0, 1'b0);
      chk({hi_supply_low_q, fade_req_q}, 2'b11);
      sup(lv[s] - 16'h0001, 1'b0, 1'b1);
      chk(speaker_off_q, 1'b1);
      sup(lv[s], 1'b0, 1'b0);
      chk({hi_supply_low_q, fade_req_q, speaker_off_q}, 3'b000);
    end
    wr(8'h06, 8'h82);
    sup(16'h0001, 1'b0, 1'b0);
    chk({hi_supply_low_q, fade_req_q}, 2'b00);
    wr(8'h06, 8'h00);
    sup(16'h6000, 1'b1, 1'b0);
    chk(fade_req_q, 1'b1);
    wr(8'h06, 8'h20);
    chk(speaker_off_q, 1'b1);
    wr(8'h06, 8'h10);
    chk({fade_req_q, speaker_off_q}, 2'b00);
    sup(16'h6000, 1'b0, 1'b0);
    final_report();
  end
endmodule : tb_avdc_regs
`default_nettype wire

/* include/avdc_pkg.sv */
// avdc_pkg: register map, field layout, reset values and states of the gain/limiter/clip bank
`default_nettype none
package avdc_pkg;
  // register offsets
  localparam logic [7:0] OFS_MASTER = 8'h03;
  localparam logic [7:0] OFS_LEFT = 8'h04;
  localparam logic [7:0] OFS_RIGHT = 8'h05;
  localparam logic [7:0] OFS_SUPPLY = 8'h06;
  localparam logic [7:0] OFS_FEAT = 8'h07;
  localparam logic [7:0] OFS_RATES = 8'h08;
  localparam logic [7:0] OFS_THR_HI = 8'h10;
  localparam logic [7:0] OFS_THR_MID = 8'h11;
  localparam logic [7:0] OFS_THR_LO = 8'h12;
  localparam logic [7:0] OFS_CLIP_HI = 8'h13;
  localparam logic [7:0] OFS_CLIP_MID = 8'h14;
  localparam logic [7:0] OFS_CLIP_LO = 8'h15;
  // reset values
  localparam logic [7:0] RST_GAIN = 8'h18;
  localparam logic [7:0] RST_SUPPLY = 8'h00;
  localparam logic [7:0] RST_FEAT = 8'h00;
  localparam logic [7:0] RST_RATES = 8'h00;
  localparam logic [7:0] RST_THR_HI = 8'h20;
  localparam logic [7:0] RST_THR_LOW = 8'h00;
  localparam logic [7:0] RST_CLIP_HI = 8'h7F;
  localparam logic [7:0] RST_CLIP_LOW = 8'hFF;
  // writable bit masks, reserved bits cleared
  localparam logic [7:0] MASK_SUPPLY = 8'hF7;
  localparam logic [7:0] MASK_FEAT = 8'hFE;
  // supply supervision field positions
  localparam int HI_LOW_OFF_BIT = 7;
  localparam int LOGIC_FADE_OFF_BIT = 6;
  localparam int OVER_FADE_OFF_BIT = 5;
  localparam int OVER_OFF_BIT = 4;
  localparam int LEVEL_SEL_LSB = 0;
  // feature enable field positions
  localparam int LEFT_MIX_BIT = 7;
  localparam int RIGHT_MIX_BIT = 6;
  localparam int LEFT_CLIP_BIT = 5;
  localparam int LEFT_LIM_BIT = 4;
  localparam int MONO_BIT = 3;
  localparam int RIGHT_CLIP_BIT = 2;
  localparam int RIGHT_LIM_BIT = 1;
  // rate fields
  localparam int ATTACK_LSB = 4;
  localparam int RELEASE_LSB = 0;
  // gain codes: half-dB steps down from +12 dB per stage
  localparam logic [7:0] GAIN_CODE_LAST = 8'hE6;
  localparam logic [8:0] TOTAL_ATT_LAST = 9'h0FE;
  // low-supply thresholds in millivolts
  localparam logic [15:0] UV_MV_0 = 16'h0FA0;
  localparam logic [15:0] UV_MV_1 = 16'h2008;
  localparam logic [15:0] UV_MV_2 = 16'h25E4;
  localparam logic [15:0] UV_MV_3 = 16'h3390;
  localparam logic [15:0] UV_MV_4 = 16'h3C8C;
  localparam logic [15:0] UV_MV_5 = 16'h4C2C;
  // serial control port states
  typedef enum logic [5:0] {
    SP_IDLE = 6'h01,
    SP_ADDR = 6'h02,
    SP_ACK = 6'h04,
    SP_WR = 6'h08,
    SP_RD = 6'h10,
    SP_RACK = 6'h20
  } avdc_sp_t;
  // output stage protection states
  typedef enum logic [2:0] {
    PR_RUN = 3'h1,
    PR_FADE = 3'h2,
    PR_OFF = 3'h4
  } avdc_prot_t;
endpackage : avdc_pkg
`default_nettype wire
